// File: src/homing_pkg.sv
// Constants, register map and carrier types for the homing sequencer.
// Assumes one 125 MHz clock and a 32-bit Avalon-MM slave port.
// Behaviour
// - Method digit 3 selects stopper-contact homing.
// - Stopper homing runs at homing speed until load meets the stopper.
// - After contact wait dwell time, then capture home and flag completion.
// - Stopper homing limits torque to the stopper torque limit.
// - Homing acceleration uses the first point-table acceleration constant.
// - On completion current position loads the home position data.
// - Torque-reached asserts at forward, reverse or internal torque limit.
// - Internal select 0 uses stopper limit; 1 uses the smaller of both.
// - Home-ignorance defines the servo-on position as home.
// - Method digit 4 selects home-ignorance without needing homing mode.
// - Dog homing slows at front end, passes rear, travels after-dog plus shift.
// - Dog rear-end homing never uses the encoder zero-phase marker.
// - Stopper homing moves in the direction set by the direction parameter.
// - Method digit 5 selects rear-end-referenced dog homing.
// - Dog homing switches to creep speed once the dog is detected.
package homing_pkg;
	localparam int CLOCK_PERIOD_NS = 8;
	localparam int MS_NS = 1000000;
	localparam int TICK_CYC = MS_NS / CLOCK_PERIOD_NS;
	localparam int TABLE_W = 8;
	localparam int IRQ_W = 2;

	////////////////////////////////////////////////////////////////////////////
	// Byte offsets of the registers.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_METHOD = 8'h04;
	localparam logic [7:0] OFS_DIR = 8'h08;
	localparam logic [7:0] OFS_HSPEED = 8'h0C;
	localparam logic [7:0] OFS_CREEP = 8'h10;
	localparam logic [7:0] OFS_HOMEDATA = 8'h14;
	localparam logic [7:0] OFS_DWELL = 8'h18;
	localparam logic [7:0] OFS_STOPTQ = 8'h1C;
	localparam logic [7:0] OFS_INTTQ = 8'h20;
	localparam logic [7:0] OFS_FWDTQ = 8'h24;
	localparam logic [7:0] OFS_REVTQ = 8'h28;
	localparam logic [7:0] OFS_SHIFT = 8'h2C;
	localparam logic [7:0] OFS_AFTER = 8'h30;
	localparam logic [7:0] OFS_ACCEL = 8'h34;
	localparam logic [7:0] OFS_STATUS = 8'h38;
	localparam logic [7:0] OFS_CURPOS = 8'h3C;
	localparam logic [7:0] OFS_IRQ_ST = 8'h40;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h44;
	localparam logic [7:0] OFS_IRQ_EN = 8'h48;

	////////////////////////////////////////////////////////////////////////////
	// Field positions and encodings.
	localparam int CTRL_AUTO_BIT = 0;
	localparam int CTRL_TABLE_LSB = 1;
	localparam int CTRL_REMOTE_BIT = 9;
	localparam int CTRL_INTLIM_BIT = 10;
	localparam int CTRL_FWD_BIT = 11;
	localparam int CTRL_REV_BIT = 12;
	localparam int CTRL_W = 11;
	localparam int ST_COMPLETE_BIT = 0;
	localparam int ST_TORQ_BIT = 1;
	localparam int ST_BUSY_BIT = 2;
	localparam int ST_REMOTE_BIT = 3;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_TORQ_BIT = 1;
	localparam logic [3:0] METHOD_STOPPER = 4'h3;
	localparam logic [3:0] METHOD_IGNORE = 4'h4;
	localparam logic [3:0] METHOD_DOG_REAR = 4'h5;
	localparam logic [31:0] RST_WORD = 32'h0;
	localparam logic [15:0] RST_HALF = 16'h0;

	// Command handed to the motion loop.
	typedef struct packed {
		logic dir;
		logic [15:0] speed;
		logic [15:0] torque_limit;
		logic [15:0] accel;
	} motion_cmd_t;
endpackage

// File: src/stopper_dwell_timer.sv
// Millisecond dwell timer started at stopper contact.
// Assumes start is a one-cycle pulse and ce gates every edge.
`timescale 1ns/10ps
module stopper_dwell_timer #(
	parameter int TICK = homing_pkg::TICK_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic start,
	input wire logic [15:0] ms,
	output logic done_q
);
	import homing_pkg::*;
	logic [$clog2(TICK)-1:0] tick_q;
	logic [15:0] left_q;
	logic run_q;

	// A dwell of zero still costs one cycle so that done never meets start.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_q <= '0;
			left_q <= RST_HALF;
			run_q <= 1'b0;
			done_q <= 1'b0;
		end else if (ce) begin
			done_q <= 1'b0;
			if (start) begin
				tick_q <= '0;
				left_q <= ms;
				run_q <= 1'b1;
			end else if (run_q) begin
				if (left_q == RST_HALF) begin
					run_q <= 1'b0;
					done_q <= 1'b1;
				end else if (tick_q == ($clog2(TICK))'(TICK - 1)) begin
					tick_q <= '0;
					left_q <= left_q - 16'h1;
				end else begin
					tick_q <= tick_q + 1'b1;
				end
			end
		end
	end
endmodule

// File: src/torque_limit_unit.sv
// Selects the active torque limit and flags when torque reaches a limit.
// Assumes torque feedback is signed and limits are magnitudes.
`timescale 1ns/10ps
module torque_limit_unit (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic stopper_active,
	input wire logic int_sel,
	input wire logic dir,
	input wire logic [15:0] stop_tq,
	input wire logic [15:0] int_tq,
	input wire logic [15:0] fwd_tq,
	input wire logic [15:0] rev_tq,
	input wire logic signed [15:0] torque_fb,
	output logic [15:0] limit_q,
	output logic reached_q
);
	import homing_pkg::*;
	logic [15:0] base;
	logic [15:0] mag;

	// Outside stopper homing the limit of the running direction applies.
	always_comb begin
		base = stopper_active ? stop_tq : (dir ? rev_tq : fwd_tq);
		mag = torque_fb[15] ? 16'(-torque_fb) : 16'(torque_fb);
	end

	// Registered limit and reached flag.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			limit_q <= RST_HALF;
			reached_q <= 1'b0;
		end else if (ce) begin
			limit_q <= (int_sel && int_tq < base) ? int_tq : base;
			reached_q <= (!torque_fb[15] && mag >= fwd_tq) ||
				(torque_fb[15] && mag >= rev_tq) ||
				(int_sel && mag >= int_tq);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_limit_select: assert property (ce && stopper_active && !int_sel |=> limit_q == $past(stop_tq)) else $error("stopper limit not applied");
	a_limit_min: assert property (ce && stopper_active && int_sel |=> limit_q <= $past(stop_tq) && limit_q <= $past(int_tq)) else $error("limit not the smaller one");
	a_torque_hit: assert property (ce && !torque_fb[15] && torque_fb >= $signed({1'b0, fwd_tq[14:0]}) && !fwd_tq[15] |=> reached_q) else $error("torque reached missing");
endmodule

// File: src/homing_sequencer.sv
// Homing sequencer: stopper, home-ignorance and dog rear-end methods.
// Assumes a 125 MHz clock, Avalon-MM host access and encoder step pulses.
`timescale 1ns/10ps
module homing_sequencer #(
	parameter int TICK_CYCLES = homing_pkg::TICK_CYC
) (
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic CE,
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	output logic IRQ,
	input wire logic SERVO_ON,
	input wire logic STOPPER_CONTACT,
	input wire logic DOG,
	input wire logic ENC_STEP,
	input wire logic ENC_DIR,
	input wire logic signed [15:0] TORQUE_FB,
	output homing_pkg::motion_cmd_t MOTION,
	output logic HOMING_COMPLETE,
	output logic TORQUE_REACHED
);
	import homing_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_DWELL, ST_FAST, ST_CREEP, ST_AFTER} state_t;

	state_t state_q;
	logic [CTRL_W-1:0] ctrl_q;
	logic [3:0] method_q;
	logic dir_q;
	logic [15:0] hspeed_q, creep_q, dwell_q, stoptq_q, inttq_q, fwdtq_q, revtq_q, accel_q;
	logic [31:0] homedata_q, shift_q, after_q, curpos_q, dist_q;
	logic [IRQ_W-1:0] irq_st_q, irq_en_q;
	logic wait_q, start_q, servo_q, dog_q, complete_q, done_evt;
	logic [31:0] rdata_d;
	logic wr_en, rd_en, manual_mode, dwell_done, tq_reached, tq_prev_q;
	logic [15:0] tq_limit;
	logic [IRQ_W-1:0] irq_set;

	////////////////////////////////////////////////////////////////////////////
	// Bus handshake: waitrequest drops for exactly one cycle per request.
	assign wr_en = AVS_WRITE && !wait_q;
	assign rd_en = AVS_READ && wait_q;

	// Waitrequest starts high so that every access costs one wait state.
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			wait_q <= 1'b1;
		end else if (CE) begin
			if (!wait_q) begin
				wait_q <= 1'b1;
			end else if (AVS_READ || AVS_WRITE) begin
				wait_q <= 1'b0;
			end
		end
	end

	// Read mux; unmapped offsets answer zero.
	always_comb begin
		rdata_d = RST_WORD;
		case (AVS_ADDRESS)
			OFS_CTRL: rdata_d[CTRL_W-1:0] = ctrl_q;
			OFS_METHOD: rdata_d[3:0] = method_q;
			OFS_DIR: rdata_d[0] = dir_q;
			OFS_HSPEED: rdata_d[15:0] = hspeed_q;
			OFS_CREEP: rdata_d[15:0] = creep_q;
			OFS_HOMEDATA: rdata_d = homedata_q;
			OFS_DWELL: rdata_d[15:0] = dwell_q;
			OFS_STOPTQ: rdata_d[15:0] = stoptq_q;
			OFS_INTTQ: rdata_d[15:0] = inttq_q;
			OFS_FWDTQ: rdata_d[15:0] = fwdtq_q;
			OFS_REVTQ: rdata_d[15:0] = revtq_q;
			OFS_SHIFT: rdata_d = shift_q;
			OFS_AFTER: rdata_d = after_q;
			OFS_ACCEL: rdata_d[15:0] = accel_q;
			OFS_STATUS: begin
				rdata_d[ST_COMPLETE_BIT] = complete_q;
				rdata_d[ST_TORQ_BIT] = tq_reached;
				rdata_d[ST_BUSY_BIT] = (state_q != ST_IDLE);
				rdata_d[ST_REMOTE_BIT] = ctrl_q[CTRL_REMOTE_BIT];
			end
			OFS_CURPOS: rdata_d = curpos_q;
			OFS_IRQ_ST: rdata_d[IRQ_W-1:0] = irq_st_q;
			OFS_IRQ_EN: rdata_d[IRQ_W-1:0] = irq_en_q;
			default: rdata_d = RST_WORD;
		endcase
	end

	// Read data is latched while waitrequest is still high.
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			AVS_READDATA <= RST_WORD;
		end else if (CE && rd_en) begin
			AVS_READDATA <= rdata_d;
		end
	end

	// Writable parameter registers.
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl_q <= '0;
			method_q <= 4'h0;
			dir_q <= 1'b0;
			{hspeed_q, creep_q, dwell_q, stoptq_q} <= {4{RST_HALF}};
			{inttq_q, fwdtq_q, revtq_q, accel_q} <= {4{RST_HALF}};
			{homedata_q, shift_q, after_q} <= {3{RST_WORD}};
			irq_en_q <= '0;
		end else if (CE && wr_en) begin
			case (AVS_ADDRESS)
				OFS_CTRL: ctrl_q <= AVS_WRITEDATA[CTRL_W-1:0];
				OFS_METHOD: method_q <= AVS_WRITEDATA[3:0];
				OFS_DIR: dir_q <= AVS_WRITEDATA[0];
				OFS_HSPEED: hspeed_q <= AVS_WRITEDATA[15:0];
				OFS_CREEP: creep_q <= AVS_WRITEDATA[15:0];
				OFS_HOMEDATA: homedata_q <= AVS_WRITEDATA;
				OFS_DWELL: dwell_q <= AVS_WRITEDATA[15:0];
				OFS_STOPTQ: stoptq_q <= AVS_WRITEDATA[15:0];
				OFS_INTTQ: inttq_q <= AVS_WRITEDATA[15:0];
				OFS_FWDTQ: fwdtq_q <= AVS_WRITEDATA[15:0];
				OFS_REVTQ: revtq_q <= AVS_WRITEDATA[15:0];
				OFS_SHIFT: shift_q <= AVS_WRITEDATA;
				OFS_AFTER: after_q <= AVS_WRITEDATA;
				OFS_ACCEL: accel_q <= AVS_WRITEDATA[15:0];
				OFS_IRQ_EN: irq_en_q <= AVS_WRITEDATA[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Start pulse from a control write carrying a forward or reverse start bit.
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			start_q <= 1'b0;
		end else if (CE) begin
			start_q <= wr_en && AVS_ADDRESS == OFS_CTRL &&
				(AVS_WRITEDATA[CTRL_FWD_BIT] || AVS_WRITEDATA[CTRL_REV_BIT]);
		end
	end

	// Homing mode needs the auto/manual bit with every table select bit clear.
	assign manual_mode = ctrl_q[CTRL_AUTO_BIT] &&
		ctrl_q[CTRL_TABLE_LSB +: TABLE_W] == '0;

	// Delayed copies of servo-on and dog for edge detection.
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			servo_q <= 1'b0;
			dog_q <= 1'b0;
		end else if (CE) begin
			servo_q <= SERVO_ON;
			dog_q <= DOG;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer. The dog path counts steps only, never a zero-phase marker.
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			state_q <= ST_IDLE;
		end else if (CE) begin
			case (state_q)
				ST_IDLE: begin
					if (start_q && manual_mode) begin
						if (method_q == METHOD_STOPPER) begin
							state_q <= ST_RUN;
						end else if (method_q == METHOD_DOG_REAR) begin
							state_q <= ST_FAST;
						end
					end
				end
				ST_RUN: if (STOPPER_CONTACT) state_q <= ST_DWELL;
				ST_DWELL: if (dwell_done) state_q <= ST_IDLE;
				ST_FAST: if (DOG) state_q <= ST_CREEP;
				ST_CREEP: if (dog_q && !DOG) state_q <= ST_AFTER;
				ST_AFTER: if (dist_q >= after_q + shift_q) state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Completion event from any of the three methods.
	assign done_evt = (state_q == ST_DWELL && dwell_done) ||
		(state_q == ST_AFTER && dist_q >= after_q + shift_q) ||
		(method_q == METHOD_IGNORE && SERVO_ON && !servo_q);

	// Distance walked past the dog rear end.
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			dist_q <= RST_WORD;
		end else if (CE) begin
			if (state_q != ST_AFTER) begin
				dist_q <= RST_WORD;
			end else if (ENC_STEP) begin
				dist_q <= dist_q + 32'h1;
			end
		end
	end

	// Current position; a completion load wins over a step in the same cycle.
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			curpos_q <= RST_WORD;
		end else if (CE) begin
			if (done_evt) begin
				curpos_q <= homedata_q;
			end else if (ENC_STEP) begin
				curpos_q <= ENC_DIR ? curpos_q - 32'h1 : curpos_q + 32'h1;
			end
		end
	end

	// Completion flag drops when a new homing run starts.
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			complete_q <= 1'b0;
		end else if (CE) begin
			if (done_evt) begin
				complete_q <= 1'b1;
			end else if (start_q && manual_mode && state_q == ST_IDLE) begin
				complete_q <= 1'b0;
			end
		end
	end

	// Command to the motion loop: speed one cycle behind the state, torque limit two cycles behind.
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			MOTION <= '0;
		end else if (CE) begin
			MOTION.dir <= dir_q;
			MOTION.accel <= accel_q;
			MOTION.torque_limit <= tq_limit;
			case (state_q)
				ST_RUN, ST_FAST: MOTION.speed <= hspeed_q;
				ST_CREEP, ST_AFTER: MOTION.speed <= creep_q;
				default: MOTION.speed <= RST_HALF;
			endcase
		end
	end

	assign HOMING_COMPLETE = complete_q;
	assign TORQUE_REACHED = tq_reached;

	////////////////////////////////////////////////////////////////////////////
	// Interrupts: a set in the same cycle as a clear wins.
	assign irq_set[IRQ_DONE_BIT] = done_evt;
	assign irq_set[IRQ_TORQ_BIT] = tq_reached && !tq_prev_q;

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			irq_st_q <= '0;
			tq_prev_q <= 1'b0;
			IRQ <= 1'b0;
		end else if (CE) begin
			tq_prev_q <= tq_reached;
			if (wr_en && AVS_ADDRESS == OFS_IRQ_CLR) begin
				irq_st_q <= (irq_st_q & ~AVS_WRITEDATA[IRQ_W-1:0]) | irq_set;
			end else begin
				irq_st_q <= irq_st_q | irq_set;
			end
			IRQ <= |(irq_st_q & irq_en_q);
		end
	end

	assign AVS_WAITREQUEST = wait_q;

	////////////////////////////////////////////////////////////////////////////
	// Leaf units.
	stopper_dwell_timer #(.TICK(TICK_CYCLES)) u_dwell (
		.clk(CLOCK),
		.rst_n(RESETN),
		.ce(CE),
		.start(state_q == ST_RUN && STOPPER_CONTACT),
		.ms(dwell_q),
		.done_q(dwell_done)
	);

	torque_limit_unit u_torque (
		.clk(CLOCK),
		.rst_n(RESETN),
		.ce(CE),
		.stopper_active(state_q == ST_RUN || state_q == ST_DWELL),
		.int_sel(ctrl_q[CTRL_INTLIM_BIT]),
		.dir(dir_q),
		.stop_tq(stoptq_q),
		.int_tq(inttq_q),
		.fwd_tq(fwdtq_q),
		.rev_tq(revtq_q),
		.torque_fb(TORQUE_FB),
		.limit_q(tq_limit),
		.reached_q(tq_reached)
	);

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESETN);
	a_stopper_select: assert property (CE && state_q == ST_IDLE && start_q && manual_mode && method_q == METHOD_STOPPER |=> state_q == ST_RUN) else $error("stopper homing not started");
	a_dog_select: assert property (CE && state_q == ST_IDLE && start_q && manual_mode && method_q == METHOD_DOG_REAR |=> state_q == ST_FAST) else $error("dog homing not started");
	a_no_auto_start: assert property (CE && state_q == ST_IDLE && !manual_mode |=> state_q == ST_IDLE) else $error("homing left idle outside manual mode");
	a_run_speed: assert property (CE && state_q == ST_RUN |=> MOTION.speed == $past(hspeed_q) && MOTION.dir == $past(dir_q)) else $error("wrong stopper speed or direction");
	a_accel_entry: assert property (CE && state_q != ST_IDLE |=> MOTION.accel == $past(accel_q)) else $error("wrong acceleration constant");
	a_dwell_capture: assert property (CE && state_q == ST_DWELL && dwell_done |=> complete_q && curpos_q == $past(homedata_q)) else $error("home not captured after dwell");
	a_ignore_home: assert property (CE && method_q == METHOD_IGNORE && $rose(SERVO_ON) |=> complete_q && curpos_q == $past(homedata_q)) else $error("servo-on not taken as home");
	a_creep_switch: assert property (CE && state_q == ST_FAST && DOG |=> state_q == ST_CREEP ##1 MOTION.speed == $past(creep_q)) else $error("creep speed not entered");
	a_rear_end: assert property (CE && state_q == ST_CREEP && dog_q && !DOG |=> state_q == ST_AFTER) else $error("dog rear end missed");
	c_stopper_done: cover property (state_q == ST_DWELL && dwell_done);
	c_dog_done: cover property (state_q == ST_AFTER ##1 state_q == ST_IDLE);
	c_ignore_done: cover property (method_q == METHOD_IGNORE && $rose(SERVO_ON));
	c_irq_raised: cover property ($rose(IRQ));
endmodule

// File: testbench/axis_model.sv
// Axis model: turns the motion command into encoder steps, stopper contact and dog.
// Assumes the sequencer asks for a nonzero speed only while the axis is to move.
`timescale 1ns/10ps
module axis_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire homing_pkg::motion_cmd_t motion,
	input wire logic [15:0] stop_at,
	input wire logic [15:0] dog_lo,
	input wire logic [15:0] dog_hi,
	output logic contact,
	output logic dog,
	output logic step_q,
	output logic step_dir,
	output logic [15:0] moved_q
);
	import homing_pkg::*;
	logic [1:0] div_q;

	////////////////////////////////////////////////////////////////////////////
	// One step every four cycles while moving; the load halts on the stopper.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 2'h0;
			step_q <= 1'h0;
			moved_q <= 16'h0;
		end else begin
			step_q <= 1'h0;
			if (clear) begin
				div_q <= 2'h0;
				moved_q <= 16'h0;
			end else if (motion.speed != 16'h0 && !contact) begin
				div_q <= div_q + 2'h1;
				if (div_q == 2'h3) begin
					step_q <= 1'h1;
					moved_q <= moved_q + 16'h1;
				end
			end
		end
	end

	// A stop distance of zero means no stopper; the dog is a window of travel.
	assign step_dir = motion.dir;
	assign contact = (stop_at != 16'h0) && (moved_q >= stop_at);
	assign dog = (moved_q >= dog_lo) && (moved_q < dog_hi);
endmodule

// File: testbench/servo_home_return_modes_bench.sv
// Bench for the homing sequencer: Avalon-MM register tasks and homing scenarios.
// Assumes the axis model stands in for the load, stopper, dog and encoder.
`timescale 1ns/10ps
module servo_home_return_modes_bench;
	import homing_pkg::*;
	localparam int TICK = 4;
	localparam int LIMIT = 60000;
	localparam logic [15:0] HSPD = 16'h0123;
	localparam logic [15:0] ACC = 16'h0077;
	localparam logic [31:0] HOME = 32'h1234_5678;
	localparam logic [15:0] TQV [0:6] = '{16'h0100, 16'h00FF, 16'hFF80, 16'hFF81,
		16'h0040, 16'hFFC0, 16'h003F};
	localparam logic TQE [0:6] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
	logic CLOCK, RESETN, CE, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IRQ, SERVO_ON;
	logic STOPPER_CONTACT, DOG, ENC_STEP, ENC_DIR, HOMING_COMPLETE, TORQUE_REACHED, CLR;
	logic [7:0] AVS_ADDRESS;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
	logic signed [15:0] TORQUE_FB;
	logic [15:0] STOP_AT, DOG_LO, DOG_HI, MOVED;
	motion_cmd_t MOTION;
	int err_total, comparisons, cyc, n;

	homing_sequencer #(.TICK_CYCLES(TICK)) i_homing_sequencer (.CLOCK(CLOCK), .RESETN(RESETN),
		.CE(CE), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ), .SERVO_ON(SERVO_ON),
		.STOPPER_CONTACT(STOPPER_CONTACT), .DOG(DOG), .ENC_STEP(ENC_STEP), .ENC_DIR(ENC_DIR),
		.TORQUE_FB(TORQUE_FB), .MOTION(MOTION), .HOMING_COMPLETE(HOMING_COMPLETE),
		.TORQUE_REACHED(TORQUE_REACHED));
	axis_model i_axis_model (.clk(CLOCK), .rst_n(RESETN), .clear(CLR), .motion(MOTION),
		.stop_at(STOP_AT), .dog_lo(DOG_LO), .dog_hi(DOG_HI), .contact(STOPPER_CONTACT),
		.dog(DOG), .step_q(ENC_STEP), .step_dir(ENC_DIR), .moved_q(MOVED));

	////////////////////////////////////////////////////////////////////////////
	// Clock and the hang guard; a run that hangs counts as a mismatch.
	initial begin
		CLOCK = 1'h0;
		forever #4 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK) begin
		cyc++;
		if (cyc == LIMIT) begin
			err_total++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// The request is held until waitrequest is sampled low; read data is taken there.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'h0);
		q = AVS_READDATA;
		AVS_WRITE <= 1'h0;
		AVS_READ <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask
	task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
		bus(1'h0, a, 32'h0);
		check(name, q, exp);
	endtask
	// Bounded wait for a level; the count tells how long it took.
	task automatic wait_sig(ref logic s, input logic v, output int k);
		k = 0;
		while (s !== v && k < 2000) begin
			@(posedge CLOCK);
			k++;
		end
	endtask
	task automatic wait_move();
		n = 0;
		while (MOTION.speed === 16'h0 && n < 200) begin
			@(posedge CLOCK);
			n++;
		end
	endtask
	task automatic clr_model(input logic [15:0] s, input logic [15:0] lo, input logic [15:0] hi);
		STOP_AT <= s;
		DOG_LO <= lo;
		DOG_HI <= hi;
		CLR <= 1'h1;
		@(posedge CLOCK);
		CLR <= 1'h0;
	endtask
	// Mode is set in its own write, well ahead of the start write.
	task automatic stopper_run(input logic isel, input logic [15:0] itq, input logic [15:0] lim);
		clr_model(16'h0006, 16'hFFFF, 16'hFFFF);
		wr(OFS_INTTQ, {16'h0, itq});
		wr(OFS_CTRL, {21'h0, isel, 1'h1, 8'h00, 1'h1});
		wr(OFS_CTRL, {21'h0, isel, 1'h1, 8'h00, 1'h1} | 32'h0000_0800);
		wait_move();
		repeat (3) @(posedge CLOCK);
		check("speed", MOTION.speed, HSPD);
		check("dir", MOTION.dir, 1'h1);
		check("accel", MOTION.accel, ACC);
		check("torque limit", MOTION.torque_limit, lim);
		check("complete early", HOMING_COMPLETE, 1'h0);
		rd("status busy", OFS_STATUS, 32'h0000_000C);
		wait_sig(STOPPER_CONTACT, 1'h1, n);
		wait_sig(HOMING_COMPLETE, 1'h1, n);
		check("dwell", n >= 2 * TICK && n <= 2 * TICK + 4, 1'h1);
		rd("position", OFS_CURPOS, HOME);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		{RESETN, AVS_READ, AVS_WRITE, SERVO_ON, CLR} = 5'h0;
		{AVS_ADDRESS, AVS_WRITEDATA} = 40'h0;
		{STOP_AT, DOG_LO, DOG_HI} = {16'h0, 16'hFFFF, 16'hFFFF};
		CE = 1'h1;
		TORQUE_FB = 16'sh0;
		repeat (10) @(posedge CLOCK);
		RESETN <= 1'h1;
		check("complete reset", HOMING_COMPLETE, 1'h0);
		check("irq reset", IRQ, 1'h0);
		rd("position reset", OFS_CURPOS, 32'h0);
		wr(8'hFC, 32'hFFFF_FFFF);
		rd("unmapped", 8'hFC, 32'h0);
		wr(OFS_CURPOS, 32'h0000_5555);
		rd("position ro", OFS_CURPOS, 32'h0);
		// Home-ignorance needs no homing mode, only a servo-on edge.
		wr(OFS_METHOD, 32'h0000_0004);
		wr(OFS_HOMEDATA, 32'hA5A5_0001);
		SERVO_ON <= 1'h1;
		wait_sig(HOMING_COMPLETE, 1'h1, n);
		check("ignore wait", n <= 3, 1'h1);
		rd("ignore position", OFS_CURPOS, 32'hA5A5_0001);
		// Stopper set-up, with torque limits that a zero torque does not reach.
		wr(OFS_METHOD, 32'h0000_0003);
		wr(OFS_DIR, 32'h0000_0001);
		wr(OFS_HSPEED, {16'h0, HSPD});
		wr(OFS_DWELL, 32'h0000_0002);
		wr(OFS_STOPTQ, 32'h0000_0050);
		wr(OFS_FWDTQ, 32'h0000_0100);
		wr(OFS_REVTQ, 32'h0000_0080);
		wr(OFS_ACCEL, {16'h0, ACC});
		wr(OFS_HOMEDATA, HOME);
		wr(OFS_IRQ_CLR, 32'h0000_0003);
		wr(OFS_IRQ_EN, 32'h0000_0001);
		rd("method", OFS_METHOD, 32'h0000_0003);
		// A start with a table bit set is not manual homing and must not move.
		wr(OFS_CTRL, 32'h0000_0003);
		wr(OFS_CTRL, 32'h0000_0803);
		repeat (20) @(posedge CLOCK);
		check("refused start", MOTION.speed, 16'h0);
		stopper_run(1'h0, 16'h0030, 16'h0050);
		rd("status", OFS_STATUS, 32'h0000_0009);
		check("irq done", IRQ, 1'h1);
		wr(OFS_IRQ_CLR, 32'h0000_0001);
		repeat (2) @(posedge CLOCK);
		check("irq cleared", IRQ, 1'h0);
		stopper_run(1'h1, 16'h0030, 16'h0030);
		stopper_run(1'h1, 16'h0070, 16'h0050);
		// Torque-reached table: forward, reverse, then internal limit.
		wr(OFS_CTRL, 32'h0000_0000);
		wr(OFS_INTTQ, 32'h0000_0040);
		wr(OFS_IRQ_EN, 32'h0000_0000);
		wr(OFS_IRQ_CLR, 32'h0000_0003);
		for (int i = 0; i < 7; i++) begin
			if (i == 4)
				wr(OFS_CTRL, 32'h0000_0400);
			TORQUE_FB <= TQV[i];
			repeat (3) @(posedge CLOCK);
			check("torque reached", TORQUE_REACHED, TQE[i]);
			if (i == 5)
				rd("status torque", OFS_STATUS, 32'h0000_0003);
		end
		rd("irq status", OFS_IRQ_ST, 32'h0000_0002);
		check("irq masked", IRQ, 1'h0);
		wr(OFS_IRQ_EN, 32'h0000_0002);
		repeat (2) @(posedge CLOCK);
		check("irq enabled", IRQ, 1'h1);
		rd("irq clear reads", OFS_IRQ_CLR, 32'h0);
		wr(OFS_IRQ_CLR, 32'h0000_0002);
		repeat (2) @(posedge CLOCK);
		check("irq off", IRQ, 1'h0);
		// Dog rear-end run: no zero-phase input, home is counted from the rear end.
		TORQUE_FB <= 16'sh0;
		wr(OFS_METHOD, 32'h0000_0005);
		wr(OFS_DIR, 32'h0000_0000);
		wr(OFS_CREEP, 32'h0000_0011);
		wr(OFS_AFTER, 32'h0000_0003);
		wr(OFS_SHIFT, 32'h0000_0002);
		wr(OFS_HOMEDATA, 32'h0000_0ABC);
		clr_model(16'h0, 16'h0004, 16'h000A);
		wr(OFS_CTRL, 32'h0000_0201);
		wr(OFS_CTRL, 32'h0000_1201);
		wait_move();
		check("complete cleared", HOMING_COMPLETE, 1'h0);
		check("dog fast", MOTION.speed, HSPD);
		wait_sig(DOG, 1'h1, n);
		repeat (3) @(posedge CLOCK);
		check("creep", MOTION.speed, 16'h0011);
		wait_sig(DOG, 1'h0, n);
		wait_sig(HOMING_COMPLETE, 1'h1, n);
		check("dog distance", MOVED == 16'h000F || MOVED == 16'h0010, 1'h1);
		rd("dog position", OFS_CURPOS, 32'h0000_0ABC);
		// A low clock enable must hold the reached flag until the enable returns.
		CE <= 1'h0;
		TORQUE_FB <= 16'sh0100;
		repeat (3) @(posedge CLOCK);
		check("ce frozen", TORQUE_REACHED, 1'h0);
		CE <= 1'h1;
		repeat (2) @(posedge CLOCK);
		check("ce running", TORQUE_REACHED, 1'h1);
		results();
	end
endmodule
